/* File: core/pdm_channel_regs.sv */
// peripheral dma channel pair: apb registers, chaining and memory requests
`timescale 1ns/1ps
module pdm_channel_regs import pdm_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// peripheral side
	input wire logic rx_ready_in,
	input wire logic [31:0] rx_data_in,
	input wire pdm_size_t rx_size_in,
	output logic rx_taken_out,
	input wire logic tx_ready_in,
	input wire pdm_size_t tx_size_in,
	output logic [31:0] tx_data_out,
	output logic tx_load_out,
	output logic rx_buffer_done_flag_out,
	output logic rx_all_buffers_done_flag_out,
	output logic tx_buffer_done_flag_out,
	output logic tx_all_buffers_done_flag_out,
	// memory side
	output pdm_mem_req_t mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [31:0] mem_rdata_in,
	output logic irq_out
);

	function automatic logic [31:0] pdm_step(input logic [31:0] ptr,
			input pdm_size_t sz);
		logic [31:0] inc;
		inc = 32'h0000_0001;
		case (sz)
			PDM_SZ_HALF: inc = 32'h0000_0002;
			PDM_SZ_WORD: inc = 32'h0000_0004;
			default: inc = 32'h0000_0001;
		endcase
		return ptr + inc;
	endfunction : pdm_step

	// counters are 16 bits wide; the upper bus bits never reach them
	function automatic logic pdm_is_zero(input logic [15:0] cnt);
		return cnt == 16'h0000;
	endfunction : pdm_is_zero

	logic [31:0] rx_ptr_reg;
	logic [15:0] rx_cnt_reg;
	logic [31:0] rx_nptr_reg;
	logic [15:0] rx_ncnt_reg;
	logic [31:0] tx_ptr_reg;
	logic [15:0] tx_cnt_reg;
	logic [31:0] tx_nptr_reg;
	logic [15:0] tx_ncnt_reg;
	logic rx_en_reg;
	logic tx_en_reg;
	logic [PDM_IRQ_W-1:0] irq_stat_reg;
	logic [PDM_IRQ_W-1:0] irq_mask_reg;
	logic [PDM_IRQ_W-1:0] flag_reg;
	logic [PDM_IRQ_W-1:0] flag_next;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_next;
	logic tx_load_reg;
	logic [31:0] tx_data_reg;
	pdm_state_t state_reg;
	pdm_mem_req_t req_reg;

	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic w_rx_ptr;
	logic w_rx_cnt;
	logic w_tx_ptr;
	logic w_tx_cnt;
	logic w_rx_nptr;
	logic w_rx_ncnt;
	logic w_tx_nptr;
	logic w_tx_ncnt;
	logic w_ctrl;
	logic w_istat;
	logic w_imask;
	logic rx_go;
	logic tx_go;
	logic rx_done;
	logic tx_done;
	logic rx_reload;
	logic tx_reload;
	logic rx_cnt_zero;
	logic rx_ncnt_zero;
	logic tx_cnt_zero;
	logic tx_ncnt_zero;
	logic rx_touch;
	logic tx_touch;

	// apb decode; every access answers in its first access cycle
	assign wr_acc = psel_in & penable_in & pwrite_in;
	assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
	assign pready_out = 1'b1;

	always_comb begin
		case (paddr_in)
			PDM_RX_CUR_PTR_OFF, PDM_RX_CUR_CNT_OFF,
			PDM_TX_CUR_PTR_OFF, PDM_TX_CUR_CNT_OFF,
			PDM_RX_NXT_PTR_OFF, PDM_RX_NXT_CNT_OFF,
			PDM_TX_NXT_PTR_OFF, PDM_TX_NXT_CNT_OFF,
			PDM_CTRL_OFF, PDM_STAT_OFF,
			PDM_IRQ_STAT_OFF, PDM_IRQ_MASK_OFF: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// writes to read-only status are refused as well
	// a refused write leaves every register as it was
	assign pslverr_out = psel_in & penable_in &
		(~mapped | (pwrite_in & (paddr_in == PDM_STAT_OFF)));

	assign w_rx_ptr = wr_acc & (paddr_in == PDM_RX_CUR_PTR_OFF);
	assign w_rx_cnt = wr_acc & (paddr_in == PDM_RX_CUR_CNT_OFF);
	assign w_tx_ptr = wr_acc & (paddr_in == PDM_TX_CUR_PTR_OFF);
	assign w_tx_cnt = wr_acc & (paddr_in == PDM_TX_CUR_CNT_OFF);
	assign w_rx_nptr = wr_acc & (paddr_in == PDM_RX_NXT_PTR_OFF);
	assign w_rx_ncnt = wr_acc & (paddr_in == PDM_RX_NXT_CNT_OFF);
	assign w_tx_nptr = wr_acc & (paddr_in == PDM_TX_NXT_PTR_OFF);
	assign w_tx_ncnt = wr_acc & (paddr_in == PDM_TX_NXT_CNT_OFF);
	assign w_ctrl = wr_acc & (paddr_in == PDM_CTRL_OFF);
	assign w_istat = wr_acc & (paddr_in == PDM_IRQ_STAT_OFF);
	assign w_imask = wr_acc & (paddr_in == PDM_IRQ_MASK_OFF);

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (paddr_in)
			PDM_RX_CUR_PTR_OFF: rdata_next = rx_ptr_reg;
			PDM_RX_CUR_CNT_OFF: rdata_next = {16'h0000, rx_cnt_reg};
			PDM_TX_CUR_PTR_OFF: rdata_next = tx_ptr_reg;
			PDM_TX_CUR_CNT_OFF: rdata_next = {16'h0000, tx_cnt_reg};
			PDM_RX_NXT_PTR_OFF: rdata_next = rx_nptr_reg;
			PDM_RX_NXT_CNT_OFF: rdata_next = {16'h0000, rx_ncnt_reg};
			PDM_TX_NXT_PTR_OFF: rdata_next = tx_nptr_reg;
			PDM_TX_NXT_CNT_OFF: rdata_next = {16'h0000, tx_ncnt_reg};
			PDM_CTRL_OFF: rdata_next = 32'h0000_0000;
			PDM_STAT_OFF: begin
				rdata_next[PDM_RX_EN_BIT] = rx_en_reg;
				rdata_next[PDM_TX_EN_BIT] = tx_en_reg;
			end
			PDM_IRQ_STAT_OFF: rdata_next[PDM_IRQ_W-1:0] = irq_stat_reg;
			PDM_IRQ_MASK_OFF: rdata_next[PDM_IRQ_W-1:0] = irq_mask_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// read data is captured in the setup cycle so prdata comes from a flop
	// a counter that moves during the access still reads its setup value
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_reg <= rdata_next;
		end
	end
	assign prdata_out = prdata_reg;

	// enable state: disable has precedence over enable
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rx_en_reg <= 1'b0;
			tx_en_reg <= 1'b0;
		end else if (w_ctrl) begin
			if (pwdata_in[PDM_RX_DIS_BIT]) begin
				rx_en_reg <= 1'b0;
			end else if (pwdata_in[PDM_RX_EN_BIT]) begin
				rx_en_reg <= 1'b1;
			end
			if (pwdata_in[PDM_TX_DIS_BIT]) begin
				tx_en_reg <= 1'b0;
			end else if (pwdata_in[PDM_TX_EN_BIT]) begin
				tx_en_reg <= 1'b1;
			end
		end
	end

	// a software write to either counter of a pair counts as a touch
	assign rx_cnt_zero = pdm_is_zero(rx_cnt_reg);
	assign rx_ncnt_zero = pdm_is_zero(rx_ncnt_reg);
	assign tx_cnt_zero = pdm_is_zero(tx_cnt_reg);
	assign tx_ncnt_zero = pdm_is_zero(tx_ncnt_reg);
	assign rx_touch = w_rx_cnt | w_rx_ncnt;
	assign tx_touch = w_tx_cnt | w_tx_ncnt;

	// a transfer is only started with a nonzero counter
	assign rx_go = rx_en_reg & ~rx_cnt_zero & rx_ready_in;
	assign tx_go = tx_en_reg & ~tx_cnt_zero & tx_ready_in &
		~tx_load_reg;
	assign rx_done = (state_reg == PDM_RX) & mem_ack_in;
	assign tx_done = (state_reg == PDM_TX) & mem_ack_in;

	// chaining waits a cycle if software touches the pair at the same edge
	// the enables do not gate chaining; a disabled pair still reloads
	assign rx_reload = rx_cnt_zero & ~rx_ncnt_zero & ~rx_touch &
		~w_rx_ptr & ~w_rx_nptr &
		(state_reg != PDM_RX);
	assign tx_reload = tx_cnt_zero & ~tx_ncnt_zero & ~tx_touch &
		~w_tx_ptr & ~w_tx_nptr &
		(state_reg != PDM_TX);

	// receive pointer and counter pair
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rx_ptr_reg <= PDM_PTR_RST;
			rx_cnt_reg <= PDM_CNT_RST;
			rx_nptr_reg <= PDM_PTR_RST;
			rx_ncnt_reg <= PDM_CNT_RST;
		end else begin
			if (w_rx_nptr) begin
				rx_nptr_reg <= pwdata_in;
			end
			if (w_rx_ncnt) begin
				rx_ncnt_reg <= pwdata_in[15:0];
			end
			if (w_rx_ptr) begin
				rx_ptr_reg <= pwdata_in;
			end else if (rx_done) begin
				rx_ptr_reg <= pdm_step(rx_ptr_reg, req_reg.size);
			end else if (rx_reload) begin
				rx_ptr_reg <= rx_nptr_reg;
			end
			if (w_rx_cnt) begin
				rx_cnt_reg <= pwdata_in[15:0];
			end else if (rx_done) begin
				rx_cnt_reg <= rx_cnt_reg - 16'h0001;
			end else if (rx_reload) begin
				rx_cnt_reg <= rx_ncnt_reg;
				rx_ncnt_reg <= PDM_CNT_RST;
			end
		end
	end

	// transmit pointer and counter pair
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tx_ptr_reg <= PDM_PTR_RST;
			tx_cnt_reg <= PDM_CNT_RST;
			tx_nptr_reg <= PDM_PTR_RST;
			tx_ncnt_reg <= PDM_CNT_RST;
		end else begin
			if (w_tx_nptr) begin
				tx_nptr_reg <= pwdata_in;
			end
			if (w_tx_ncnt) begin
				tx_ncnt_reg <= pwdata_in[15:0];
			end
			if (w_tx_ptr) begin
				tx_ptr_reg <= pwdata_in;
			end else if (tx_done) begin
				tx_ptr_reg <= pdm_step(tx_ptr_reg, req_reg.size);
			end else if (tx_reload) begin
				tx_ptr_reg <= tx_nptr_reg;
			end
			if (w_tx_cnt) begin
				tx_cnt_reg <= pwdata_in[15:0];
			end else if (tx_done) begin
				tx_cnt_reg <= tx_cnt_reg - 16'h0001;
			end else if (tx_reload) begin
				tx_cnt_reg <= tx_ncnt_reg;
				tx_ncnt_reg <= PDM_CNT_RST;
			end
		end
	end

	// transfer sequencer: receive is served before transmit
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_reg <= PDM_IDLE;
			req_reg <= '0;
		end else begin
			case (state_reg)
				PDM_IDLE: begin
					if (rx_go) begin
						state_reg <= PDM_RX;
						req_reg.valid <= 1'b1;
						req_reg.write <= 1'b1;
						req_reg.size <= rx_size_in;
						req_reg.addr <= rx_ptr_reg;
						req_reg.wdata <= rx_data_in;
					end else if (tx_go) begin
						state_reg <= PDM_TX;
						req_reg.valid <= 1'b1;
						req_reg.write <= 1'b0;
						req_reg.size <= tx_size_in;
						req_reg.addr <= tx_ptr_reg;
						req_reg.wdata <= 32'h0000_0000;
					end
				end
				PDM_RX, PDM_TX: begin
					if (mem_ack_in) begin
						state_reg <= PDM_IDLE;
						req_reg.valid <= 1'b0;
					end
				end
				default: begin
					state_reg <= PDM_IDLE;
					req_reg.valid <= 1'b0;
				end
			endcase
		end
	end
	assign mem_req_out = req_reg;

	// the peripheral drops its ready on this pulse, before idle resamples
	assign rx_taken_out = rx_done;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tx_load_reg <= 1'b0;
			tx_data_reg <= 32'h0000_0000;
		end else begin
			tx_load_reg <= tx_done;
			if (tx_done) begin
				tx_data_reg <= mem_rdata_in;
			end
		end
	end
	assign tx_load_out = tx_load_reg;
	assign tx_data_out = tx_data_reg;

	// end flags follow the counters; a counter write forces them low a cycle
	always_comb begin
		flag_next[PDM_IRQ_RX_END] = rx_cnt_zero & ~rx_touch;
		flag_next[PDM_IRQ_RX_BUFF] = rx_cnt_zero & rx_ncnt_zero &
			~rx_touch;
		flag_next[PDM_IRQ_TX_END] = tx_cnt_zero & ~tx_touch;
		flag_next[PDM_IRQ_TX_BUFF] = tx_cnt_zero & tx_ncnt_zero &
			~tx_touch;
	end

	// counters reset to zero, so the flags start set: no false edge at release
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			flag_reg <= {PDM_IRQ_W{1'b1}};
		end else begin
			flag_reg <= flag_next;
		end
	end
	assign rx_buffer_done_flag_out = flag_reg[PDM_IRQ_RX_END];
	assign rx_all_buffers_done_flag_out = flag_reg[PDM_IRQ_RX_BUFF];
	assign tx_buffer_done_flag_out = flag_reg[PDM_IRQ_TX_END];
	assign tx_all_buffers_done_flag_out = flag_reg[PDM_IRQ_TX_BUFF];

	// sticky interrupt status: a rising flag sets, write one clears, set wins
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg &
				~(w_istat ? pwdata_in[PDM_IRQ_W-1:0] : '0)) |
				(flag_next & ~flag_reg);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			irq_mask_reg <= '0;
		end else if (w_imask) begin
			irq_mask_reg <= pwdata_in[PDM_IRQ_W-1:0];
		end
	end

	// built only from registers, so bus activity cannot glitch the line
	assign irq_out = |(irq_stat_reg & irq_mask_reg);

endmodule : pdm_channel_regs

/* File: core/pdm_pkg.sv */
// constants and types for the peripheral dma channel register block
// Overview of operation
// - ten channel registers sit at offsets 0x100 through 0x124
// - receive current counter is 16 bits, upper bits read zero
// - transmit current pointer is a full 32-bit read address
// - transmit current counter is 16 bits of transfers still to do
// - a zero transmit counter stops transmit transfers
// - receive next pointer becomes the address of the following buffer
// - receive next counter is 16 bits, size of the following buffer
// - transfer control at 0x120 is write only, reads zero
// - transfer status at 0x124 is read only, zero after reset
// - pointer and counter registers are read/write and reset to zero
// - at zero count, next pair loads into current, next counter clears
// - each transfer adds 1, 2 or 4 to pointer, counter decrements
// - end and both-done flags per direction, counter writes clear them
// - enable bits set, disable bits clear, disable wins together
package pdm_pkg;

	localparam logic [11:0] PDM_RX_CUR_PTR_OFF = 12'h100;
	localparam logic [11:0] PDM_RX_CUR_CNT_OFF = 12'h104;
	localparam logic [11:0] PDM_TX_CUR_PTR_OFF = 12'h108;
	localparam logic [11:0] PDM_TX_CUR_CNT_OFF = 12'h10c;
	localparam logic [11:0] PDM_RX_NXT_PTR_OFF = 12'h110;
	localparam logic [11:0] PDM_RX_NXT_CNT_OFF = 12'h114;
	localparam logic [11:0] PDM_TX_NXT_PTR_OFF = 12'h118;
	localparam logic [11:0] PDM_TX_NXT_CNT_OFF = 12'h11c;
	localparam logic [11:0] PDM_CTRL_OFF = 12'h120;
	localparam logic [11:0] PDM_STAT_OFF = 12'h124;
	localparam logic [11:0] PDM_IRQ_STAT_OFF = 12'h128;
	localparam logic [11:0] PDM_IRQ_MASK_OFF = 12'h12c;

	// control and status bit positions
	localparam int PDM_RX_EN_BIT = 0;
	localparam int PDM_RX_DIS_BIT = 1;
	localparam int PDM_TX_EN_BIT = 8;
	localparam int PDM_TX_DIS_BIT = 9;

	// interrupt status / mask bit positions
	localparam int PDM_IRQ_RX_END = 0;
	localparam int PDM_IRQ_RX_BUFF = 1;
	localparam int PDM_IRQ_TX_END = 2;
	localparam int PDM_IRQ_TX_BUFF = 3;
	localparam int PDM_IRQ_W = 4;

	localparam logic [31:0] PDM_PTR_RST = 32'h0000_0000;
	localparam logic [15:0] PDM_CNT_RST = 16'h0000;
	localparam logic [31:0] PDM_STAT_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		PDM_SZ_BYTE = 2'h0,
		PDM_SZ_HALF = 2'h1,
		PDM_SZ_WORD = 2'h2
	} pdm_size_t;

	typedef enum logic [2:0] {
		PDM_IDLE = 3'b001,
		PDM_RX = 3'b010,
		PDM_TX = 3'b100
	} pdm_state_t;

	// one memory transfer request towards the system bus
	typedef struct packed {
		logic valid;
		logic write;
		pdm_size_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pdm_mem_req_t;

endpackage : pdm_pkg

/* File: tb/pdm_channel_regs_bench.sv */
// self-checking bench for the dma channel register block
`timescale 1ns/1ps
module pdm_channel_regs_bench import pdm_pkg::*; ;
	logic core_clk = 1'b0;
	logic rst, psel, penable, pwrite, rx_ready, tx_ready, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rx_data, tx_data, rdata, seed, pend;
	logic pready, pslverr, taken, load, ack, irq;
	logic rx_end, rx_all, tx_end, tx_all;
	pdm_size_t rx_size, tx_size;
	pdm_mem_req_t req;
	logic [33:0] apb_q[$];
	logic [66:0] xf_q[$];
	logic [33:0] ae;
	logic [66:0] xe;
	int miscompares, cmp_count, cycles;
	always #4 core_clk = ~core_clk;
	pdm_channel_regs u_pdm_channel_regs (
		.core_clk_in(core_clk), .rst_in(rst), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rx_ready_in(rx_ready), .rx_data_in(rx_data),
		.rx_size_in(rx_size), .rx_taken_out(taken), .tx_ready_in(tx_ready),
		.tx_size_in(tx_size), .tx_data_out(tx_data), .tx_load_out(load),
		.rx_buffer_done_flag_out(rx_end),
		.rx_all_buffers_done_flag_out(rx_all),
		.tx_buffer_done_flag_out(tx_end),
		.tx_all_buffers_done_flag_out(tx_all), .mem_req_out(req),
		.mem_ack_in(ack), .mem_rdata_in(rdata), .irq_out(irq));
	pdm_mem_model u_pdm_mem_model (.core_clk_in(core_clk), .rst_in(rst),
		.mem_req_in(req), .slow_in(slow), .mem_ack_out(ack),
		.mem_rdata_out(rdata));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// e holds {refused, read data}; the watcher compares at the access edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e);
		apb_q.push_back({!w, e});
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk iff pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask : rd
	task automatic rx_item(input logic [31:0] a, input pdm_size_t s);
		seed = lfsr(seed);
		xf_q.push_back({1'b1, s, a, seed});
		@(posedge core_clk);
		rx_ready <= 1'b1;
		rx_data <= seed;
		rx_size <= s;
		@(posedge core_clk iff taken);
		rx_ready <= 1'b0;
		rx_data <= ~seed;
	endtask : rx_item
	always @(posedge core_clk) begin
		cycles++;
		if (!rst && psel && penable && pready) begin
			ae = apb_q.pop_front();
			chk(pslverr === ae[32] && (!ae[33] || prdata === ae[31:0]), "apb");
		end
		// an empty queue pops unknowns, so a stray transfer fails here
		if (!rst && req.valid && ack) begin
			xe = xf_q.pop_front();
			chk(req.addr === xe[63:32] && req.write === xe[66] &&
				req.size === xe[65:64], "address");
			if (xe[66]) chk(req.wdata === xe[31:0] && taken, "rx word");
			pend = xe[31:0];
		end
		if (!rst && load) chk(tx_data === pend, "tx word");
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		{psel, penable, pwrite, rx_ready, tx_ready, slow} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		rx_data = 32'h0;
		rx_size = PDM_SZ_BYTE;
		tx_size = PDM_SZ_WORD;
		seed = 32'h0001728a;
		pend = 32'h0;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		rst = 1'b1;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) rd(12'h100 + 12'(i * 4), 33'h0);
		rd(12'h200, 33'h1_0000_0000);
		apb(1'b1, 12'h124, 32'hffffffff, 33'h1_0000_0000);
		rd(12'h124, 33'h0);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(12'h100 + 12'(i * 4), seed);
			rd(12'h100 + 12'(i * 4), {1'b0, i[0] ? {16'h0, seed[15:0]} : seed});
		end
		slow <= 1'b1;
		wr(12'h100, 32'h1000);
		wr(12'h104, 32'h2);
		wr(12'h110, 32'h2000);
		wr(12'h114, 32'h1);
		wr(12'h120, 32'h1);
		rx_item(32'h1000, PDM_SZ_BYTE);
		rx_item(32'h1001, PDM_SZ_HALF);
		rx_item(32'h2000, PDM_SZ_WORD);
		repeat (4) @(posedge core_clk);
		rd(12'h100, 33'h2004);
		rd(12'h104, 33'h0);
		rd(12'h114, 33'h0);
		#1;
		chk(rx_end === 1'b1 && rx_all === 1'b1, "rx flags");
		slow <= 1'b0;
		wr(12'h108, 32'h3000);
		wr(12'h10c, 32'h2);
		wr(12'h11c, 32'h0);
		wr(12'h120, 32'h300);
		rd(12'h120, 33'h0);
		rd(12'h124, 33'h1);
		xf_q.push_back({1'b0, PDM_SZ_WORD, 32'h3000, 32'h3000cfff});
		xf_q.push_back({1'b0, PDM_SZ_WORD, 32'h3004, 32'h3004cffb});
		tx_ready <= 1'b1;
		wr(12'h120, 32'h100);
		rd(12'h124, 33'h101);
		repeat (30) @(posedge core_clk);
		tx_ready <= 1'b0;
		chk(xf_q.size() == 0 && tx_all === 1'b1, "tx stop");
		wr(12'h120, 32'h202);
		rd(12'h124, 33'h0);
		wr(12'h12c, 32'h0);
		wr(12'h128, 32'hf);
		wr(12'h104, 32'h0);
		repeat (3) @(posedge core_clk);
		#1;
		chk(irq === 1'b0, "masked irq");
		wr(12'h12c, 32'h1);
		rd(12'h12c, 33'h1);
		#1;
		chk(irq === 1'b1, "irq raised");
		wr(12'h128, 32'h1);
		#1;
		chk(irq === 1'b0, "irq cleared");
		print_verdict();
	end
endmodule : pdm_channel_regs_bench

/* File: tb/pdm_channel_regs_monitor.sv */
// concurrent checks on the dma channel register block ports
`timescale 1ns/1ps
module pdm_channel_regs_monitor import pdm_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic rx_taken_out,
	input wire logic [31:0] tx_data_out,
	input wire logic tx_load_out,
	input wire logic tx_buffer_done_flag_out,
	input wire logic tx_all_buffers_done_flag_out,
	input wire pdm_mem_req_t mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [31:0] mem_rdata_in
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	logic acc;
	logic done;
	logic mapped;
	assign acc = psel_in && penable_in;
	assign done = mem_req_out.valid && mem_ack_in;
	assign mapped = paddr_in >= 12'h100 && paddr_in <= 12'h12c
		&& paddr_in[1:0] == 2'h0;
	AST_STAT_RO: assert property (
		acc && pwrite_in && paddr_in == 12'h124 |-> pslverr_out)
		else $error("status write not refused");
	AST_MAP_OK: assert property (
		acc && mapped && !(pwrite_in && paddr_in == 12'h124) |-> !pslverr_out)
		else $error("mapped access refused");
	AST_REQ_HOLD: assert property (
		mem_req_out.valid && !mem_ack_in |=> $stable(mem_req_out))
		else $error("memory request changed before ack");
	AST_ONE_GAP: assert property (
		done |=> !mem_req_out.valid)
		else $error("no idle cycle after transfer");
	AST_RX_TAKEN: assert property (
		rx_taken_out || done |-> rx_taken_out == (done && mem_req_out.write))
		else $error("rx taken not tied to write ack");
	AST_TX_LOAD: assert property (
		done && !mem_req_out.write |=>
		tx_load_out && tx_data_out == $past(mem_rdata_in))
		else $error("tx load missing or wrong data");
	AST_LOAD_CAUSE: assert property (
		tx_load_out |-> $past(done && !mem_req_out.write))
		else $error("tx load without read ack");
	AST_TX_STOP: assert property (
		tx_all_buffers_done_flag_out && $past(tx_all_buffers_done_flag_out)
		|-> !($rose(mem_req_out.valid) && !mem_req_out.write))
		else $error("tx transfer with zero count");
	AST_FLAG_CLR: assert property (
		acc && pready_out && pwrite_in && paddr_in == 12'h10c
		|=> !tx_buffer_done_flag_out)
		else $error("counter write left flag set");
endmodule : pdm_channel_regs_monitor
bind pdm_channel_regs pdm_channel_regs_monitor u_mon (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out),
	.rx_taken_out(rx_taken_out), .tx_data_out(tx_data_out),
	.tx_load_out(tx_load_out),
	.tx_buffer_done_flag_out(tx_buffer_done_flag_out),
	.tx_all_buffers_done_flag_out(tx_all_buffers_done_flag_out),
	.mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in),
	.mem_rdata_in(mem_rdata_in));

/* File: tb/pdm_mem_model.sv */
// memory responder at the dma side, answers promptly or after a stall
`timescale 1ns/1ps
module pdm_mem_model import pdm_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire pdm_mem_req_t mem_req_in,
	input wire logic slow_in,
	output logic mem_ack_out,
	output logic [31:0] mem_rdata_out
);
	logic [2:0] wait_reg;
	logic go;
	assign go = mem_req_in.valid && !mem_ack_out
		&& (!slow_in || wait_reg == 3'h3);
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !mem_req_in.valid || mem_ack_out) begin
			wait_reg <= 3'h0;
		end else begin
			wait_reg <= wait_reg + 3'h1;
		end
	end
	always_ff @(posedge core_clk_in) begin
		mem_ack_out <= !rst_in && go;
	end
	// off the answer the bus toggles, so stale data can never match
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			mem_rdata_out <= 32'h0;
		end else if (go) begin
			mem_rdata_out <= {mem_req_in.addr[15:0], ~mem_req_in.addr[15:0]};
		end else begin
			mem_rdata_out <= ~mem_rdata_out;
		end
	end
endmodule : pdm_mem_model
